// ==== test/tasc_sva.sv ====
// Link checker for the touch converter serial control
`timescale 1ns/1ps
`default_nettype none
module tasc_sva (
  input wire logic reset_n_i,
  input wire logic serial_clock_in,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic busy,
  input wire logic busy_oe_n,
  input wire logic pen_touch_irq_n_oe_n
);
  // ==========================================================
  // Edges since select fell; saturates so long runs stay quiet
  logic [7:0] cnt_q;
  logic res8_q;

  always_ff @(posedge serial_clock_in or posedge cs_n
              or negedge reset_n_i) begin
    if (!reset_n_i || cs_n) begin
      cnt_q <= 8'h00;
      res8_q <= 1'b0;
    end else begin
      if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
      if (cnt_q == 8'h04) res8_q <= din;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge serial_clock_in);
  endclocking
  default disable iff (!reset_n_i);

  sequence quiet_s;
    !busy [*7];
  endsequence

  sequence tail_s;
    cnt_q inside {[21:23]};
  endsequence

  sclk_in_frame_a: assert property (!cs_n)
    else $error("serial clock edge while deselected");
  oe_drive_a: assert property (cnt_q != 8'h00 |-> !dout_oe_n && !busy_oe_n)
    else $error("outputs not driven inside frame");
  busy_start_a: assert property ($rose(busy) |-> $past(din, 8))
    else $error("busy without a start bit");
  busy_slot_a: assert property (busy && cnt_q != 8'hFF |-> cnt_q[3:0] == 4'h8)
    else $error("busy not after eighth control bit");
  busy_gap_a: assert property (busy |=> quiet_s)
    else $error("busy repeated too soon");
  tail_zero_a: assert property (tail_s |-> !dout)
    else $error("data after last result bit");
  short_zero_a: assert property (res8_q && cnt_q inside {[17:20]} |-> !dout)
    else $error("low resolution result too long");
  pen_mask_a: assert property (cnt_q inside {[2:20]} |-> pen_touch_irq_n_oe_n)
    else $error("pen request inside frame");
endmodule
`default_nettype wire

// ==== test/test_touch_adc_serial_control.sv ====
// Bench for both link ends of the touch converter serial control
`timescale 1ns/1ps
`default_nettype none
module test_touch_adc_serial_control;
  import tasc_pkg::*;
  logic ref_clk_i, reset_n_i, cmd_valid_i, fast_i, pen_touch_i;
  logic [7:0] cmd_byte_i, ctl_byte_o;
  logic [SAMPLE_W-1:0] sample_data_i, result_o;
  logic cmd_ready_o, result_valid_o, pen_irq_o, res8_o;
  logic [1:0] ain_sel_o;
  logic x_sw_on_o, y_sw_on_o, yneg_sw_on_o, adc_keep_power_o, pen_irq_en_o;
  logic [15:0] cfg_seen;
  int n_errors = 0;
  int samples_checked = 0;
  int edges = 0;
  int takes = 0;
  logic [SAMPLE_W-1:0] exp_q[$];

  assign cfg_seen = {ctl_byte_o, ain_sel_o, res8_o, x_sw_on_o, y_sw_on_o,
    yneg_sw_on_o, adc_keep_power_o, pen_irq_en_o};

  tasc_if link ();
  // Small divider keeps frames short; host makes the link clock
  tasc_host #(.HALF_CYC(2)) u_tasc_host (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .link(link), .cmd_valid_i(cmd_valid_i),
    .cmd_byte_i(cmd_byte_i), .fast_i(fast_i), .cmd_ready_o(cmd_ready_o),
    .result_o(result_o), .result_valid_o(result_valid_o),
    .pen_irq_o(pen_irq_o));
  tasc_dev u_tasc_dev (.reset_n_i(reset_n_i), .link(link),
    .sample_data_i(sample_data_i), .pen_touch_i(pen_touch_i),
    .conv_start_o(), .result_done_o(), .ctl_byte_o(ctl_byte_o),
    .ain_sel_o(ain_sel_o), .res8_o(res8_o), .x_sw_on_o(x_sw_on_o),
    .y_sw_on_o(y_sw_on_o), .yneg_sw_on_o(yneg_sw_on_o),
    .adc_keep_power_o(adc_keep_power_o), .pen_irq_en_o(pen_irq_en_o));
  tasc_sva u_tasc_sva (.reset_n_i(reset_n_i),
    .serial_clock_in(link.serial_clock_in), .cs_n(link.cs_n),
    .din(link.din), .dout(link.dout), .dout_oe_n(link.dout_oe_n),
    .busy(link.busy), .busy_oe_n(link.busy_oe_n),
    .pen_touch_irq_n_oe_n(link.pen_touch_irq_n_oe_n));

  // ==========================================================
  // Expectations and reporting
  function automatic logic [15:0] exp_cfg(input logic [7:0] b);
    logic [1:0] p;
    logic [1:0] a;
    p = (b[1:0] == 2'b10) ? 2'b11 : b[1:0];
    a = b[6:5];
    return {1'b1, b[6:2], p, a, b[3], a == 2'b10, a == 2'b00,
      a == 2'b00 || p == 2'b00, p == 2'b11, p == 2'b00};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic give_up();
    n_errors++;
    end_of_test();
  endtask

  // ==========================================================
  // Command and settle tasks
  task automatic send(input logic [7:0] b, input logic f);
    int i;
    i = 0;
    while (cmd_ready_o !== 1'b1) begin
      @(negedge ref_clk_i);
      i++;
      if (i > 3000) give_up();
    end
    cmd_valid_i = 1'b1;
    cmd_byte_i = b;
    fast_i = f;
    sample_data_i = SAMPLE_W'($urandom);
    exp_q.push_back(b[3] ? {4'h0, sample_data_i[11:4]} : sample_data_i);
    takes++;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b0;
  endtask

  task automatic settle(input logic [7:0] b);
    int i;
    i = 0;
    while (exp_q.size() != 0 || cmd_ready_o !== 1'b1) begin
      @(negedge ref_clk_i);
      i++;
      if (i > 5000) give_up();
    end
    check(cfg_seen, exp_cfg(b));
    pen_touch_i = 1'($urandom);
    // Two-stage sync on the host plus one cycle of margin
    repeat (3) @(negedge ref_clk_i);
    check({15'h0, pen_irq_o}, {15'h0, pen_touch_i & (b[1:0] == 2'b00)});
    check({14'h0, link.dout_line, link.busy_line}, 16'h0003);
  endtask

  // ==========================================================
  // Monitors
  // Looked at mid-cycle, away from the edge that launches the pulse
  always @(negedge ref_clk_i) begin
    if (result_valid_o === 1'b1)
      check({4'h0, result_o}, {4'h0, exp_q.size() != 0 ? exp_q.pop_front() : ~result_o});
  end

  always @(posedge link.serial_clock_in) edges++;

  always @(posedge link.cs_n) begin
    if (reset_n_i === 1'b1 && takes != 0)
      check(16'(edges), 16'(8 + 16 * takes));
    edges = 0;
    takes = 0;
  end

  // ==========================================================
  // Clock and main sequence
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    logic [7:0] b;
    reset_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_byte_i = 8'h00;
    fast_i = 1'b0;
    pen_touch_i = 1'b0;
    sample_data_i = '0;
    b = 8'($urandom(32'h1C0A35EB));
    repeat (16) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    @(negedge ref_clk_i);
    // Every channel and power code, start bit often left low
    for (int i = 0; i < 16; i++) begin
      b = 8'($urandom);
      b[6:5] = i[1:0];
      b[1:0] = i[3:2];
      b[3] = i[0] ^ i[2];
      send(b, 1'b0);
      settle(b);
    end
    repeat (12) begin
      b = 8'($urandom);
      send(b, 1'b0);
      settle(b);
    end
    // Overlapped frames, next byte sent during readout
    repeat (3) begin
      for (int k = 0; k < 4; k++) begin
        b = 8'($urandom);
        send(b, 1'b1);
      end
      settle(b);
    end
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== verilog/tasc_dev.sv ====
// Converter end: serial control logic clocked by the link clock
`timescale 1ns/1ps
`default_nettype none
module tasc_dev
  import tasc_pkg::*;
#(
  parameter int SW = SAMPLE_W
) (
  input wire logic reset_n_i,
  tasc_if.dev link,
  input wire logic [SW-1:0] sample_data_i,
  input wire logic pen_touch_i,
  output logic conv_start_o,
  output logic result_done_o,
  output logic [7:0] ctl_byte_o,
  output logic [1:0] ain_sel_o,
  output logic res8_o,
  output logic x_sw_on_o,
  output logic y_sw_on_o,
  output logic yneg_sw_on_o,
  output logic adc_keep_power_o,
  output logic pen_irq_en_o
);

  // ==========================================================
  // State
  typedef enum logic {
    D_SCAN,
    D_CTRL
  } tasc_dst_t;

  typedef struct packed {
    tasc_dst_t st;
    logic [3:0] cnt;
    logic [7:0] ctl;
    logic busy;
    logic [SW-1:0] out;
    logic [3:0] left;
    logic done;
    logic oe_n;
    logic start;
  } tasc_frame_t;

  typedef struct packed {
    logic [7:0] byte_q;
    logic [1:0] ain;
    logic res8;
    logic [1:0] pwr;
    logic x_sw;
    logic y_sw;
    logic yneg;
    logic keep;
    logic pen_en;
  } tasc_cfg_t;

  tasc_frame_t fr_q;
  tasc_frame_t fr_d;
  tasc_cfg_t cf_q;
  tasc_cfg_t cf_d;
  logic frame_rst_n;
  logic [7:0] byte_v;
  logic [1:0] ain_v;
  logic [1:0] pwr_v;

  // Select high holds the frame logic in reset, so the link clock
  // may stop between frames and every frame opens from a clean
  // scan state after the falling edge of select.
  assign frame_rst_n = reset_n_i & ~link.cs_n;

  // ==========================================================
  // Next state
  always_comb begin
    fr_d = fr_q;
    cf_d = cf_q;
    byte_v = {fr_q.ctl[6:0], link.din};
    ain_v = ctl_ain(byte_v);
    pwr_v = ctl_pwr(byte_v);

    // Lines stay released until the first edge after select falls
    fr_d.oe_n = 1'b0;
    fr_d.start = 1'b0;
    fr_d.busy = 1'b0;
    fr_d.done = 1'b0;

    // Result shifter runs on its own, so a new control byte can
    // be taken in while the previous result drains; the sample is
    // loaded on the edge after busy so its top bit leads the readout
    if (fr_q.busy) begin
      if (cf_q.res8) begin
        fr_d.out = {sample_data_i[SW-1 -: LOW_RES_W],
                    {(SW-LOW_RES_W){1'b0}}};
        fr_d.left = RX_BITS_LOW;
      end else begin
        fr_d.out = sample_data_i;
        fr_d.left = RX_BITS_FULL;
      end
    end else begin
      fr_d.out = {fr_q.out[SW-2:0], 1'b0};
      if (fr_q.left != 4'h0) begin
        fr_d.left = fr_q.left - 4'h1;
        fr_d.done = (fr_q.left == 4'h1);
      end
    end

    unique case (fr_q.st)
      D_SCAN: begin
        // Low bits before the start bit are ignored, also those
        // that arrive while a result is still going out
        if (link.din) begin
          fr_d.st = D_CTRL;
          fr_d.cnt = 4'h1;
          fr_d.ctl = CTRL_FIRST;
        end
      end
      D_CTRL: begin
        fr_d.ctl = byte_v;
        fr_d.cnt = fr_q.cnt + 4'h1;
        if (fr_q.cnt == CTRL_LAST_CNT) begin
          fr_d.st = D_SCAN;
          fr_d.busy = 1'b1;
          fr_d.start = 1'b1;
          cf_d.byte_q = byte_v;
          cf_d.ain = ain_v;
          cf_d.res8 = ctl_res8(byte_v);
          cf_d.pwr = pwr_v;
          cf_d.x_sw = (ain_v == AIN_YP);
          cf_d.y_sw = (ain_v == AIN_XP);
          // Y- also stays on in the pen-detect power-down mode
          cf_d.yneg = (ain_v == AIN_XP) ||
                      (pwr_v == PWR_DOWN_PEN);
          cf_d.keep = (pwr_v == PWR_ON);
          // The unused code behaves as pen disabled, powered down
          cf_d.pen_en = (pwr_v == PWR_DOWN_PEN);
        end
      end
    endcase
  end

  // ==========================================================
  // Frame registers, cleared whenever select is high
  always_ff @(posedge link.serial_clock_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr_q <= '0;
      fr_q.oe_n <= 1'b1;
    end else begin
      fr_q <= fr_d;
    end
  end

  // ==========================================================
  // Configuration registers, kept across frames
  always_ff @(posedge link.serial_clock_in or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cf_q <= '0;
      cf_q.yneg <= 1'b1;
      cf_q.pen_en <= 1'b1;
    end else begin
      cf_q <= cf_d;
    end
  end

  // ==========================================================
  // Link outputs
  assign link.dout = fr_q.out[SW-1];
  assign link.dout_oe_n = fr_q.oe_n;
  assign link.busy = fr_q.busy;
  assign link.busy_oe_n = fr_q.oe_n;
  // Pen request must work with the link clock stopped, so it is
  // gated from the touch level directly; it is masked in frames
  // because the panel drivers disturb the touch sense then.
  assign link.pen_touch_irq_n_oe_n =
    ~(cf_q.pen_en & pen_touch_i & fr_q.oe_n);

  // ==========================================================
  // User side outputs
  assign conv_start_o = fr_q.start;
  assign result_done_o = fr_q.done;
  assign ctl_byte_o = cf_q.byte_q;
  assign ain_sel_o = cf_q.ain;
  assign res8_o = cf_q.res8;
  assign x_sw_on_o = cf_q.x_sw;
  assign y_sw_on_o = cf_q.y_sw;
  assign yneg_sw_on_o = cf_q.yneg;
  assign adc_keep_power_o = cf_q.keep;
  assign pen_irq_en_o = cf_q.pen_en;

endmodule
`default_nettype wire

// ==== verilog/tasc_host.sv ====
// Host end: serial master that makes the link clock by division
`timescale 1ns/1ps
`default_nettype none
module tasc_host
  import tasc_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  tasc_if.host link,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic fast_i,
  output logic cmd_ready_o,
  output logic [SAMPLE_W-1:0] result_o,
  output logic result_valid_o,
  output logic pen_irq_o
);

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_HIGH,
    H_LOW,
    H_CLOSE
  } tasc_hst_t;

  typedef struct packed {
    tasc_hst_t st;
    logic [7:0] div;
    logic [4:0] slot;
    logic [7:0] tx;
    logic [3:0] rx_left;
    logic rx_res8;
    logic cur_res8;
    logic [SAMPLE_W-1:0] rx;
    logic [SAMPLE_W-1:0] result;
    logic rvalid;
    logic ready;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout_s1;
    logic dout_s2;
    logic pen_s1;
    logic pen_s2;
  } tasc_host_t;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
  localparam logic [7:0] HALF_PRE = 8'(HALF_CYC - 2);

  tasc_host_t h_q;
  tasc_host_t h_d;
  logic last;
  logic [7:0] cmd_v;
  logic [SAMPLE_W-1:0] rx_v;

  // The unused power code is never sent; it is raised to the
  // powered code, the nearest one that keeps the pen off
  function automatic logic [7:0] clean_cmd(input logic [7:0] c);
    logic [7:0] r;
    r = c;
    r[START_POS] = 1'b1;
    if (ctl_pwr(c) == PWR_UNUSED) begin
      r[PWR_LO_POS] = 1'b1;
    end
    return r;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    h_d = h_q;
    cmd_v = clean_cmd(cmd_byte_i);
    rx_v = {h_q.rx[SAMPLE_W-2:0], h_q.dout_s2};
    last = (h_q.div == HALF_LAST);
    h_d.dout_s1 = link.dout_line;
    h_d.dout_s2 = h_q.dout_s1;
    h_d.pen_s1 = link.pen_touch_irq_n;
    h_d.pen_s2 = h_q.pen_s1;
    h_d.rvalid = 1'b0;
    h_d.ready = 1'b0;
    h_d.div = last ? 8'h00 : h_q.div + 8'h01;

    unique case (h_q.st)
      H_IDLE: begin
        h_d.div = 8'h00;
        h_d.ready = 1'b1;
        if (cmd_valid_i && h_q.ready) begin
          h_d.ready = 1'b0;
          h_d.tx = cmd_v;
          h_d.din = cmd_v[START_POS];
          h_d.cur_res8 = ctl_res8(cmd_v);
          h_d.slot = 5'h00;
          h_d.cs_n = 1'b0;
          h_d.st = H_SETUP;
        end
      end
      H_SETUP, H_LOW: begin
        if (last) begin
          // Sample the settled bit just before the rising edge
          if (h_q.rx_left != 4'h0) begin
            h_d.rx = rx_v;
            h_d.rx_left = h_q.rx_left - 4'h1;
            if (h_q.rx_left == 4'h1) begin
              h_d.rvalid = 1'b1;
              h_d.result = h_q.rx_res8 ?
                {{(SAMPLE_W-LOW_RES_W){1'b0}}, rx_v[LOW_RES_W-1:0]} :
                rx_v;
            end
          end
          h_d.sclk = 1'b1;
          h_d.slot = h_q.slot + 5'h01;
          if (h_q.slot + 5'h01 == SLOT_DATA) begin
            h_d.rx_res8 = h_q.cur_res8;
            h_d.rx_left = h_q.cur_res8 ? RX_BITS_LOW : RX_BITS_FULL;
          end
          h_d.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (h_q.div == HALF_PRE && h_q.slot == SLOT_FAST && fast_i) begin
          h_d.ready = 1'b1;
        end
        if (last) begin
          h_d.sclk = 1'b0;
          h_d.st = H_LOW;
          if (h_q.slot == SLOT_FAST && h_q.ready && cmd_valid_i) begin
            // Next byte goes out while the result still drains
            h_d.tx = cmd_v;
            h_d.din = cmd_v[START_POS];
            h_d.cur_res8 = ctl_res8(cmd_v);
            h_d.slot = 5'h00;
          end else if (h_q.slot == SLOT_STD) begin
            h_d.cs_n = 1'b1;
            h_d.din = 1'b0;
            h_d.st = H_CLOSE;
          end else begin
            h_d.tx = {h_q.tx[6:0], 1'b0};
            h_d.din = h_q.tx[6];
          end
        end
      end
      H_CLOSE: begin
        if (last) begin
          h_d.st = H_IDLE;
        end
      end
      default: begin
        h_d.st = H_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      h_q <= '0;
      h_q.cs_n <= 1'b1;
      h_q.dout_s1 <= 1'b1;
      h_q.dout_s2 <= 1'b1;
      h_q.pen_s1 <= 1'b1;
      h_q.pen_s2 <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  // ==========================================================
  // Outputs
  assign link.serial_clock_in = h_q.sclk;
  assign link.cs_n = h_q.cs_n;
  assign link.din = h_q.din;
  assign cmd_ready_o = h_q.ready;
  assign result_o = h_q.result;
  assign result_valid_o = h_q.rvalid;
  assign pen_irq_o = ~h_q.pen_s2;

endmodule
`default_nettype wire

// ==== verilog/tasc_if.sv ====
// Serial link between the converter and its host
`timescale 1ns/1ps
`default_nettype none
interface tasc_if;
  logic serial_clock_in;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe_n;
  logic busy;
  logic busy_oe_n;
  logic pen_touch_irq_n_oe_n;
  logic dout_line;
  logic busy_line;
  logic pen_touch_irq_n;

  // ==========================================================
  // Wire levels; released lines read high as if pulled up
  assign dout_line = dout_oe_n ? 1'b1 : dout;
  assign busy_line = busy_oe_n ? 1'b1 : busy;
  assign pen_touch_irq_n = pen_touch_irq_n_oe_n ? 1'b1 : 1'b0;

  modport dev (
    input serial_clock_in,
    input cs_n,
    input din,
    output dout,
    output dout_oe_n,
    output busy,
    output busy_oe_n,
    output pen_touch_irq_n_oe_n
  );

  modport host (
    output serial_clock_in,
    output cs_n,
    output din,
    input dout_line,
    input busy_line,
    input pen_touch_irq_n
  );
endinterface
`default_nettype wire

// ==== verilog/tasc_pkg.sv ====
// Shared constants, control byte layout and decode helpers
// Function
// - Transaction starts only on select falling edge; an overlapped transaction starts at its start bit with select still low
// - No conversion before a start bit
// - Control byte begins at first high bit
// - Host raises select after each transaction; with fast_i it holds select low between overlapped transactions
// - Control byte shifted in first eight clocks
// - Byte: start, channel, resolution, power-down
// - Standard conversion spans 24 serial clocks
// - Upper channel bits route converter input
// - Channel choice sets X and Y switches
// - Resolution bit picks 12 or 8 bits
// - Code 00: power down, Y- on, pen on
// - Code 01: power down, Y- off, pen off
// - Code 11 stays powered; code 10 unused
// - Next control byte may overlap result readout
package tasc_pkg;

  // ==========================================================
  // Control byte layout
  localparam int CTRL_BITS = 8;
  localparam int START_POS = 7;
  localparam int CHAN_HI_POS = 6;
  localparam int CHAN_MID_POS = 5;
  localparam int CHAN_LO_POS = 4;
  localparam int RES_HI_POS = 3;
  localparam int RES_LO_POS = 2;
  localparam int PWR_HI_POS = 1;
  localparam int PWR_LO_POS = 0;
  localparam logic [3:0] CTRL_LAST_CNT = 4'(CTRL_BITS - 1);
  localparam logic [7:0] CTRL_FIRST = 8'h01;

  // ==========================================================
  // Input routing and power codes
  localparam logic [1:0] AIN_XP = 2'b00;
  localparam logic [1:0] AIN_YP = 2'b10;
  localparam logic [1:0] AIN_AUX_A = 2'b01;
  localparam logic [1:0] AIN_AUX_B = 2'b11;
  localparam logic [1:0] PWR_DOWN_PEN = 2'b00;
  localparam logic [1:0] PWR_DOWN_NOPEN = 2'b01;
  localparam logic [1:0] PWR_UNUSED = 2'b10;
  localparam logic [1:0] PWR_ON = 2'b11;

  // ==========================================================
  // Result and frame timing
  localparam int SAMPLE_W = 12;
  localparam int LOW_RES_W = 8;
  localparam logic [3:0] RX_BITS_FULL = 4'(SAMPLE_W);
  localparam logic [3:0] RX_BITS_LOW = 4'(LOW_RES_W);
  localparam logic [4:0] SLOT_STD = 5'd24;
  localparam logic [4:0] SLOT_FAST = 5'd16;
  localparam logic [4:0] SLOT_DATA = 5'd9;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_HALF_NS = 25;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Field decode
  function automatic logic ctl_res8(input logic [7:0] c);
    return c[RES_HI_POS];
  endfunction

  function automatic logic [1:0] ctl_ain(input logic [7:0] c);
    return {c[CHAN_HI_POS], c[CHAN_MID_POS]};
  endfunction

  function automatic logic [1:0] ctl_pwr(input logic [7:0] c);
    return {c[PWR_HI_POS], c[PWR_LO_POS]};
  endfunction

endpackage
